/* File: verilog/lsrf_core.sv */
// lamp sequencer: power-on delay, strike sweep, run check, fault
// Notes on behaviour
// [R1] gate drives stay off during the power-on delay of about 100 ms
// [R2] delay restarts on each rise of supply or enable
// [R3] strike starts as soon as the delay has counted out
// [R4] four lamp current cycles counted from strike start mean ignition
// [R5] no ignition within about 350 ms of strike gives fault
// [R6] strike sweeps frequency from run value up to about three times it
// [R7] strike ends after six sweeps or ignition: run or fault
// [R8] over-voltage or over-current freezes the sweep until strike ends
// [R9] only one strike per off-then-on of supply or enable
// [R10] ignition returns frequency control to the fixed run value
// [R11] in run, fewer than four lamp cycles per period gives fault
// [R12] fault holds both gate drives low
// [R13] fault clears only by cycling enable or the supply
// [R14] lost external dim clock in external digital dimming shuts down
// [R15] lamp short or open beyond about 350 ms gives fault
// [R16] selection input picks analog amplitude or digital burst dimming
// [R17] external dim clock gives one burst per 512 clock periods
// [R18] internal burst is the oscillator divided by 1024
// [R19] dual control: lamp current follows the dim clock level
// [R20] analog polarity follows dim clock tied high or low
// [R21] digital duty direct or inverse by static dim clock level
// [R22] each sweep has 512 frequency steps
// [R23] sixteen output pulses per strike step
// [R24] run check period spans 2048 lamp cycles
// [R25] selection low and dim clock high picks internal clocking
// [R26] burst counter below digitised brightness drives the lamp
// [R27] enable low or supply in lockout holds the power-on delay
module lsrf_core
    import lsrf_pkg::*;
#(
    parameter int unsigned POD_CYCLES_P      = POD_CYCLES,
    parameter int unsigned STRIKE_CYCLES_P   = STRIKE_CYCLES,
    parameter int unsigned LAMP_ABN_CYCLES_P = LAMP_ABN_CYCLES,
    parameter int unsigned DIM_IDLE_CYCLES_P = DIM_IDLE_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // power and enable
    input  wire logic       enable,
    input  wire logic       main_supply_ok,
    // oscillator, one pulse per oscillator period
    input  wire logic       osc_tick,
    // lamp feedback comparators
    input  wire logic       lamp_current_sense,
    input  wire logic       overvoltage_sense,
    input  wire logic       overcurrent_sense,
    input  wire logic       lamp_abnormal,
    // dimming control
    input  wire logic       dim_select_analog,
    input  wire logic       dim_clock_in,
    input  wire logic [8:0] brightness_in,
    // drive and status
    output logic            gate_drive_a,
    output logic            gate_drive_b,
    output logic [8:0]      sweep_step,
    output logic [3:0]      mode_state,
    output logic [8:0]      amplitude_reference,
    output logic            burst_on
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        lsrf_mode_t  mode;
        logic [2:0]  ign;
        logic [3:0]  pulses;
        logic [8:0]  step;
        logic [2:0]  sweeps;
        logic        freeze;
        logic [11:0] ticks;
        logic [2:0]  run_cnt;
        logic        lamp_prev;
        logic        phase;
        logic        gate_a;
        logic        gate_b;
        logic [8:0]  amp;
    } lsrf_core_t;

    lsrf_core_t s_q;
    lsrf_core_t s_d;
    logic       power_on;
    logic       lamp_edge;
    logic [2:0] ign_next;
    logic [2:0] run_next;
    logic       drive;
    logic       pod_done;
    logic       strike_done;
    logic       abn_done;
    logic       dim_active;
    logic       dim_lost;

    assign power_on  = enable & main_supply_ok;
    assign lamp_edge = lamp_current_sense & ~s_q.lamp_prev;
    assign ign_next  = s_q.ign + {2'h0, lamp_edge};
    assign run_next  = (s_q.run_cnt == IGNITE_CYCLES) ? s_q.run_cnt
                     : s_q.run_cnt + {2'h0, lamp_edge};

    // ----------------------------------------------------------------
    // timers and burst generator
    // ----------------------------------------------------------------
    // [R1] counter-timed power-on delay
    lsrf_timer #(
        .LIMIT (POD_CYCLES_P)
    ) u_pod_timer (
        .clk    (clk),
        .resetn (resetn),
        .run    (s_q.mode == MODE_POD && power_on),
        .done_q (pod_done)
    );

    // [R5] strike timeout
    lsrf_timer #(
        .LIMIT (STRIKE_CYCLES_P)
    ) u_strike_timer (
        .clk    (clk),
        .resetn (resetn),
        .run    (s_q.mode == MODE_STRIKE),
        .done_q (strike_done)
    );

    // [R15] short or open lamp timer
    lsrf_timer #(
        .LIMIT (LAMP_ABN_CYCLES_P)
    ) u_abn_timer (
        .clk    (clk),
        .resetn (resetn),
        .run    (lamp_abnormal && (s_q.mode == MODE_STRIKE
                                   || s_q.mode == MODE_RUN)),
        .done_q (abn_done)
    );

    lsrf_burst #(
        .IDLE_CYCLES (DIM_IDLE_CYCLES_P)
    ) u_burst (
        .clk               (clk),
        .resetn            (resetn),
        .osc_tick          (osc_tick),
        .restart           (s_q.mode == MODE_POD),
        .dim_select_analog (dim_select_analog),
        .dim_clock_in      (dim_clock_in),
        .brightness_in     (brightness_in),
        .burst_on_q        (burst_on),
        .dim_active_q      (dim_active),
        .dim_lost_q        (dim_lost)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.lamp_prev = lamp_current_sense;
        if (osc_tick) begin
            s_d.phase = ~s_q.phase;
        end
        // [R12] drives only in strike or run
        drive = (s_q.mode == MODE_STRIKE)
             || (s_q.mode == MODE_RUN && burst_on);
        s_d.gate_a = drive & ~s_q.phase;
        s_d.gate_b = drive & s_q.phase;
        // [R20] analog amplitude polarity
        if (!dim_select_analog) begin
            s_d.amp = AMP_FULL;
        end else if (!dim_active && !dim_clock_in) begin
            s_d.amp = ~brightness_in;
        end else begin
            s_d.amp = brightness_in;
        end
        unique case (s_q.mode)
            MODE_POD: begin
                s_d.ign = '0;
                s_d.pulses = '0;
                s_d.step = '0;
                s_d.sweeps = '0;
                s_d.freeze = 1'b0;
                // [R3] delay done enters strike
                if (pod_done) begin
                    s_d.mode = MODE_STRIKE;
                end
            end
            MODE_STRIKE: begin
                s_d.ign = ign_next;
                // [R4] ignition after four cycles
                if (ign_next >= IGNITE_CYCLES) begin
                    s_d.mode = MODE_RUN;
                    // [R10] back to run frequency
                    s_d.step = '0;
                    s_d.ticks = '0;
                    s_d.run_cnt = '0;
                // [R7] six sweeps without ignition
                end else if (strike_done || abn_done
                             || s_q.sweeps == SWEEP_LIMIT) begin
                    s_d.mode = MODE_FAULT;
                end else begin
                    // [R8] comparator trip freezes sweep
                    if (overvoltage_sense || overcurrent_sense) begin
                        s_d.freeze = 1'b1;
                    end
                    // [R23] sixteen pulses per step
                    if (osc_tick && !s_d.freeze) begin
                        s_d.pulses = s_q.pulses + 4'h1;
                        if (s_q.pulses == STEP_PULSES_M1) begin
                            // [R6] step raises frequency
                            s_d.step = s_q.step + 9'h1;
                            // [R22] 512 steps per sweep
                            if (s_q.step == SWEEP_LAST) begin
                                s_d.sweeps = s_q.sweeps + 3'h1;
                            end
                        end
                    end
                end
            end
            MODE_RUN: begin
                s_d.run_cnt = run_next;
                if (osc_tick) begin
                    s_d.ticks = s_q.ticks + 12'h1;
                end
                if (abn_done || dim_lost) begin
                    s_d.mode = MODE_FAULT;
                // [R24] period of 2048 lamp cycles
                end else if (osc_tick && s_q.ticks == CHECK_TICKS_M1) begin
                    s_d.run_cnt = '0;
                    // [R11] too few lamp cycles
                    if (run_next < IGNITE_CYCLES) begin
                        s_d.mode = MODE_FAULT;
                    end
                end
            end
            MODE_FAULT: begin
                // [R13] held until power cycle
                s_d.mode = MODE_FAULT;
            end
            default: begin
                s_d.mode = MODE_POD;
            end
        endcase
        // [R27] off or lockout holds delay
        // [R2] each rise restarts the delay
        // [R9] strike only reached from delay
        if (!power_on) begin
            s_d.mode = MODE_POD;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.mode <= MODE_POD;
        end else begin
            s_q <= s_d;
        end
    end

    assign gate_drive_a        = s_q.gate_a;
    assign gate_drive_b        = s_q.gate_b;
    assign sweep_step          = s_q.step;
    assign mode_state          = s_q.mode;
    assign amplitude_reference = s_q.amp;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_pod_gates_off: assert property ( // [R1]
        s_q.mode == MODE_POD |=> !gate_drive_a && !gate_drive_b)
        else $error("gate drive active during power-on delay");
    a_pod_to_strike: assert property ( // [R3]
        s_q.mode == MODE_POD && pod_done && power_on
        |=> s_q.mode == MODE_STRIKE)
        else $error("strike not entered after delay");
    a_ignite_run: assert property ( // [R4]
        s_q.mode == MODE_STRIKE && power_on && s_q.ign == 3'h3
        && lamp_edge |=> s_q.mode == MODE_RUN)
        else $error("ignition did not enter run");
    a_freeze_hold: assert property ( // [R8]
        (s_q.mode == MODE_STRIKE && s_q.freeze) ##1
        s_q.mode == MODE_STRIKE |-> $stable(s_q.step))
        else $error("frozen strike step moved");
    a_no_retry: assert property ( // [R9]
        s_q.mode == MODE_RUN || s_q.mode == MODE_FAULT
        |=> s_q.mode != MODE_STRIKE)
        else $error("strike re-entered without power cycle");
    a_run_freq: assert property ( // [R10]
        s_q.mode == MODE_RUN |-> s_q.step == 9'h0)
        else $error("run not at fixed frequency");
    a_run_check: assert property ( // [R11]
        s_q.mode == MODE_RUN && power_on && osc_tick
        && s_q.ticks == CHECK_TICKS_M1 && run_next < IGNITE_CYCLES
        |=> s_q.mode == MODE_FAULT)
        else $error("extinguished lamp not faulted");
    a_fault_low: assert property ( // [R12]
        s_q.mode == MODE_FAULT |=> !gate_drive_a && !gate_drive_b)
        else $error("gate drive active in fault");
    a_fault_sticky: assert property ( // [R13]
        s_q.mode == MODE_FAULT && power_on |=> s_q.mode == MODE_FAULT)
        else $error("fault left without power cycle");
    a_off_holds_pod: assert property ( // [R27]
        !power_on |=> s_q.mode == MODE_POD [*2])
        else $error("disabled device left delay");

    c_strike_run: cover property (
        s_q.mode == MODE_STRIKE ##1 s_q.mode == MODE_RUN);
    c_run_fault: cover property (
        s_q.mode == MODE_RUN ##1 s_q.mode == MODE_FAULT);
    c_freeze: cover property (
        s_q.mode == MODE_STRIKE && !s_q.freeze ##1 s_q.freeze);

endmodule : lsrf_core

/* File: shared/lsrf_pkg.sv */
// constants and types shared by the lamp strike/run/fault sequencer
package lsrf_pkg;

    // ----------------------------------------------------------------
    // clock and times
    // ----------------------------------------------------------------
    localparam int CLK_KHZ         = 10000;
    localparam int POD_MS          = 100;
    localparam int STRIKE_MS       = 350;
    localparam int LAMP_ABN_MS     = 350;
    localparam int DIM_IDLE_US     = 1000;
    localparam int POD_CYCLES      = POD_MS * CLK_KHZ;
    localparam int STRIKE_CYCLES   = STRIKE_MS * CLK_KHZ;
    localparam int LAMP_ABN_CYCLES = LAMP_ABN_MS * CLK_KHZ;
    localparam int DIM_IDLE_CYCLES = DIM_IDLE_US * CLK_KHZ / 1000;

    // ----------------------------------------------------------------
    // counts
    // ----------------------------------------------------------------
    localparam logic [2:0]  IGNITE_CYCLES = 3'h4;
    localparam logic [2:0]  SWEEP_LIMIT   = 3'h6;
    localparam logic [3:0]  STEP_PULSES_M1 = 4'hf;
    localparam logic [8:0]  SWEEP_LAST    = 9'h1ff;
    localparam logic [11:0] CHECK_TICKS_M1 = 12'hfff;
    localparam logic [8:0]  AMP_FULL      = 9'h1ff;

    // ----------------------------------------------------------------
    // modes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_POD    = 4'h1,
        MODE_STRIKE = 4'h2,
        MODE_RUN    = 4'h4,
        MODE_FAULT  = 4'h8
    } lsrf_mode_t;

endpackage : lsrf_pkg

/* File: verilog/lsrf_timer.sv */
// cycle timer: counts while run is high, flags when the limit is reached
module lsrf_timer
    import lsrf_pkg::*;
#(
    parameter int unsigned LIMIT = 1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // control
    input  wire logic run,
    output logic      done_q
);

    typedef struct packed {
        logic [23:0] cnt;
        logic        done;
    } lsrf_tmr_t;

    lsrf_tmr_t s_q;
    lsrf_tmr_t s_d;

    always_comb begin
        s_d = s_q;
        if (!run) begin
            s_d = '0;
        end else if (s_q.cnt == 24'(LIMIT - 1)) begin
            s_d.done = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 24'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done_q = s_q.done;

endmodule : lsrf_timer

/* File: verilog/lsrf_burst.sv */
// dimming burst generator and dim clock activity watch
module lsrf_burst
    import lsrf_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = DIM_IDLE_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // timing and control
    input  wire logic       osc_tick,
    input  wire logic       restart,
    input  wire logic       dim_select_analog,
    input  wire logic       dim_clock_in,
    input  wire logic [8:0] brightness_in,
    // status
    output logic            burst_on_q,
    output logic            dim_active_q,
    output logic            dim_lost_q
);

    typedef struct packed {
        logic [9:0]  div;
        logic [8:0]  ext_pos;
        logic [23:0] idle;
        logic        clk_prev;
        logic        active;
        logic        ext_seen;
        logic        lost;
        logic        on;
    } lsrf_brst_t;

    lsrf_brst_t s_q;
    lsrf_brst_t s_d;
    logic       edge_seen;
    logic [8:0] pos_int;

    assign edge_seen = dim_clock_in & ~s_q.clk_prev;
    assign pos_int   = s_q.div[9:1];

    always_comb begin
        s_d = s_q;
        s_d.clk_prev = dim_clock_in;
        // restart clears first, so a set in the same cycle wins
        if (restart) begin
            s_d.ext_seen = 1'b0;
            s_d.lost = 1'b0;
        end
        // internal burst: oscillator divided by 1024
        // [R18] internal divide chain
        if (osc_tick) begin
            s_d.div = s_q.div + 10'h1;
        end
        // [R17] external 512 divide
        if (edge_seen) begin
            s_d.ext_pos = s_q.ext_pos + 9'h1;
        end
        if (edge_seen) begin
            s_d.idle = '0;
        end else if (s_q.idle != 24'(IDLE_CYCLES)) begin
            s_d.idle = s_q.idle + 24'h1;
        end
        s_d.active = (s_d.idle != 24'(IDLE_CYCLES));
        // [R16] analog or digital
        if (dim_select_analog) begin
            // [R19] follow undivided clock
            s_d.on = s_q.active ? dim_clock_in : 1'b1;
        end else if (s_q.active) begin
            // [R26] position below brightness
            s_d.on = (s_q.ext_pos < brightness_in);
            s_d.ext_seen = 1'b1;
        end else begin
            // [R21] static level sets polarity
            // [R25] held high selects internal clock
            s_d.on = dim_clock_in ? (pos_int < brightness_in)
                                  : (pos_int < ~brightness_in);
        end
        // [R14] external clock stopped
        if (!dim_select_analog && s_q.ext_seen && !s_q.active) begin
            s_d.lost = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // pin idles high through its pull-up: no false edge after reset
            s_q          <= '0;
            s_q.clk_prev <= 1'b1;
            s_q.idle     <= 24'(IDLE_CYCLES);
        end else begin
            s_q <= s_d;
        end
    end

    assign burst_on_q   = s_q.on;
    assign dim_active_q = s_q.active;
    assign dim_lost_q   = s_q.lost;

endmodule : lsrf_burst

/* File: test/lsrf_lamp_model.sv */
// partner model: oscillator ticks, lamp current comparator, dim clock
module lsrf_lamp_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // scenario controls
    input  wire logic lamp_lit,
    input  wire logic dim_pulse,
    input  wire logic dim_level,
    // towards the sequencer
    output logic      osc_tick,
    output logic      lamp_current_sense,
    output logic      dim_clock_in
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] phase = 2'h0;

    // ----------------------------------------------------------------
    // tick every second clock, one lamp cycle per two ticks
    // ----------------------------------------------------------------
    always @(negedge clk or negedge resetn) begin
        if (!resetn) begin
            phase              <= 2'h0;
            osc_tick           <= 1'b0;
            lamp_current_sense <= 1'b0;
        end else begin
            phase    <= phase + 2'h1;
            osc_tick <= phase[0];
            // comparator idles low while the lamp is dark
            if (lamp_lit && phase[0]) begin
                lamp_current_sense <= ~lamp_current_sense;
            end else if (!lamp_lit) begin
                lamp_current_sense <= 1'b0;
            end
        end
    end

    // static level or a four-cycle pulse train
    assign dim_clock_in = dim_pulse ? phase[1] : dim_level;
endmodule : lsrf_lamp_model

/* File: test/lsrf_core_test.sv */
// self-checking bench for the lamp sequencer core
module lsrf_core_test
    import lsrf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk       = 1'b0;
    logic       resetn    = 1'b0;
    logic       enable    = 1'b0;
    logic       supply_ok = 1'b1;
    logic       lamp_lit  = 1'b0;
    logic       dim_pulse = 1'b0;
    logic       dim_level = 1'b1;
    logic       ov        = 1'b0;
    logic       oc        = 1'b0;
    logic       abnormal  = 1'b0;
    logic       dim_sel   = 1'b1;
    logic [8:0] bright    = 9'h0a5;
    logic       osc_tick;
    logic       lamp_sense;
    logic       dim_clk;
    logic       gate_drive_a;
    logic       gate_drive_b;
    logic [8:0] sweep_step;
    logic [3:0] mode_state;
    logic [8:0] amplitude_reference;
    logic       burst_on;
    logic [8:0] s0;
    int         num_errors = 0;
    int         checks     = 0;
    int         cycles     = 0;
    int         cnt_a;
    int         cnt_b;
    int         cnt_c;
    logic [8:0] dim_b [4]  = '{9'h100, 9'h000, 9'h100, 9'h040};
    int         dim_exp [4] = '{1024, 0, 1020, 256};

    always #50 clk = ~clk;

    lsrf_core #(
        .POD_CYCLES_P      (50),
        .STRIKE_CYCLES_P   (3000),
        .LAMP_ABN_CYCLES_P (100),
        .DIM_IDLE_CYCLES_P (40)
    ) i_dut (
        .clk                 (clk),
        .resetn              (resetn),
        .enable              (enable),
        .main_supply_ok      (supply_ok),
        .osc_tick            (osc_tick),
        .lamp_current_sense  (lamp_sense),
        .overvoltage_sense   (ov),
        .overcurrent_sense   (oc),
        .lamp_abnormal       (abnormal),
        .dim_select_analog   (dim_sel),
        .dim_clock_in        (dim_clk),
        .brightness_in       (bright),
        .gate_drive_a        (gate_drive_a),
        .gate_drive_b        (gate_drive_b),
        .sweep_step          (sweep_step),
        .mode_state          (mode_state),
        .amplitude_reference (amplitude_reference),
        .burst_on            (burst_on)
    );

    lsrf_lamp_model i_lamp (
        .clk                (clk),
        .resetn             (resetn),
        .lamp_lit           (lamp_lit),
        .dim_pulse          (dim_pulse),
        .dim_level          (dim_level),
        .osc_tick           (osc_tick),
        .lamp_current_sense (lamp_sense),
        .dim_clock_in       (dim_clk)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [11:0] seen,
                         input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic wait_mode(input logic [3:0] m, input int lim);
        for (int i = 0; i < lim && mode_state !== m; i++) begin
            @(negedge clk);
        end
        check("mode", mode_state, m);
    endtask : wait_mode

    task automatic measure(input int n);
        cnt_a = 0;
        cnt_b = 0;
        cnt_c = 0;
        repeat (n) begin
            @(negedge clk);
            cnt_a += (gate_drive_a === 1'b1);
            cnt_b += (burst_on === 1'b1);
            cnt_c += (gate_drive_b === 1'b1);
        end
    endtask : measure

    // off then on through one source, then wait out the delay
    task automatic power_up(input bit by_supply);
        if (by_supply) begin
            supply_ok = 1'b0;
        end else begin
            enable = 1'b0;
        end
        cyc(3);
        check("mode", mode_state, MODE_POD);
        supply_ok = 1'b1;
        enable    = 1'b1;
        cyc(45);
        check("mode", mode_state, MODE_POD);
        check("gates", {gate_drive_a, gate_drive_b}, 2'b00);
        wait_mode(MODE_STRIKE, 10);
    endtask : power_up

    task automatic bring_up(input bit by_supply);
        lamp_lit = 1'b1;
        power_up(by_supply);
        wait_mode(MODE_RUN, 40);
    endtask : bring_up

    // ----------------------------------------------------------------
    // hang guard
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        cyc(5);
        check("gates", {gate_drive_a, gate_drive_b}, 2'b00);
        resetn = 1'b1;
        cyc(20);
        check("mode", mode_state, MODE_POD);
        power_up(1'b0);
        s0 = sweep_step;
        cyc(128);
        check("step", 9'(sweep_step - s0), 9'h004);
        ov = 1'b1;
        cyc(3);
        ov = 1'b0;
        s0 = sweep_step;
        cyc(100);
        check("step", sweep_step, s0);
        lamp_lit = 1'b1;
        wait_mode(MODE_RUN, 40);
        check("step", sweep_step, 9'h000);
        cyc(3);
        check("amp", amplitude_reference, 9'h0a5);
        measure(40);
        check("gate_a", cnt_a, 20);
        check("gate_b", cnt_c, 20);
        dim_level = 1'b0;
        cyc(3);
        check("amp", amplitude_reference, 9'h15a);
        // back to a static high level while analog, so digital mode
        // never sees a lone rising edge as an external dim clock
        dim_level = 1'b1;
        cyc(50);
        check("amp", amplitude_reference, 9'h0a5);
        dim_sel = 1'b0;
        for (int i = 0; i < 4; i++) begin
            dim_level = (i != 2);
            dim_pulse = (i == 3);
            bright    = dim_b[i];
            cyc(50);
            measure(2048);
            check("duty", cnt_b, dim_exp[i]);
        end
        check("amp", amplitude_reference, 9'h1ff);
        dim_sel = 1'b1;
        cyc(50);
        measure(2048);
        check("duty", cnt_b, 1024);
        dim_sel = 1'b0;
        cyc(50);
        check("mode", mode_state, MODE_RUN);
        dim_pulse = 1'b0;
        wait_mode(MODE_FAULT, 60);
        cyc(2);
        check("gates", {gate_drive_a, gate_drive_b}, 2'b00);
        dim_sel = 1'b1;
        bring_up(1'b0);
        lamp_lit = 1'b0;
        wait_mode(MODE_FAULT, 17000);
        bring_up(1'b1);
        abnormal = 1'b1;
        cyc(90);
        check("mode", mode_state, MODE_RUN);
        wait_mode(MODE_FAULT, 20);
        abnormal = 1'b0;
        lamp_lit = 1'b0;
        power_up(1'b0);
        oc = 1'b1;
        cyc(5);
        s0 = sweep_step;
        cyc(100);
        check("step", sweep_step, s0);
        wait_mode(MODE_FAULT, 3100);
        cyc(300);
        check("mode", mode_state, MODE_FAULT);
        check("gates", {gate_drive_a, gate_drive_b}, 2'b00);
        tally_and_finish();
    end
endmodule : lsrf_core_test
